/* rtl/cfd_pkg.sv */
// shared constants and types for the charger fault and pack detect sequencer
package cfd_pkg;

    // interval figures as printed, in milliseconds
    localparam int DRAIN1_MS = 1000;
    localparam int WAKE_MS = 500;
    localparam int DRAIN2_MS = 1000;
    localparam int CLK_HZ = 10000000;
    // timebase tick every millisecond
    localparam int TICK_CYCLES = CLK_HZ / 1000;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_IRQ = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_CMP = 8'h10;

    // ctrl bit positions
    localparam int CTRL_TFAULT = 0;
    localparam int CTRL_FULL = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // event bit positions
    localparam int EV_TFAULT = 0;
    localparam int EV_OVP = 1;
    localparam int EV_ABSENT = 2;
    localparam int EV_PRESENT = 3;
    localparam int EV_PERMIT = 4;
    localparam int EV_W = 5;
    localparam logic [4:0] MASK_RST = 5'h00;

    typedef enum logic [8:0] {
        CFD_CHARGE  = 9'h001,
        CFD_DONE    = 9'h002,
        CFD_TFHIGH  = 9'h004,
        CFD_TFPROBE = 9'h008,
        CFD_OVP     = 9'h010,
        CFD_DRAIN1  = 9'h020,
        CFD_WAKE    = 9'h040,
        CFD_ABSENT  = 9'h080,
        CFD_DRAIN2  = 9'h100
    } cfd_state_t;

    // analog comparator results
    typedef struct packed {
        logic aboveRecharge;
        logic belowShort;
        logic overVolt;
        logic sleepExit;
    } cfd_cmp_t;

    // current source and converter enables
    typedef struct packed {
        logic pwmEn;
        logic probeEn;
        logic drain1En;
        logic wakeEn;
        logic drain2En;
    } cfd_drive_t;

endpackage

/* rtl/cfd_interval.sv */
// phase interval timer driven by the millisecond tick
`timescale 1ns/10ps
module cfd_interval #(
    parameter int CNT_W = 11
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic start,
    input wire logic [CNT_W-1:0] loadMs,
    output logic expired
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic run_r;
    logic run_nxt;
    logic exp_r;
    logic exp_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        exp_nxt = 1'b0;
        if (start) begin
            cnt_nxt = loadMs;
            run_nxt = 1'b1;
        end else if (run_r && tick) begin
            if (cnt_r <= CNT_W'(1)) begin
                run_nxt = 1'b0;
                exp_nxt = 1'b1;
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expired = exp_r;
endmodule

/* rtl/cfd_sequencer.sv */
// charger fault recovery and pack-absent detect sequencer with AHB-Lite registers
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
module cfd_sequencer #(
    parameter int DRAIN1_MS = cfd_pkg::DRAIN1_MS,
    parameter int WAKE_MS = cfd_pkg::WAKE_MS,
    parameter int DRAIN2_MS = cfd_pkg::DRAIN2_MS,
    parameter logic [15:0] TICK_LAST = cfd_pkg::TICK_LAST
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire cfd_pkg::cfd_cmp_t cmpIn,
    input wire logic permitN,
    output cfd_pkg::cfd_drive_t drive,
    output logic adapterPresentOutOe,
    output logic [1:0] chargeIndicatorPinsOe,
    output logic irq
);
    localparam int CW = 11;

    ////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [4:0] syncA_r;
    logic [4:0] syncB_r;
    cfd_pkg::cfd_cmp_t cmp;
    logic permitNs;
    logic permitPrev_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncA_r <= 5'h00;
            syncB_r <= 5'h00;
            permitPrev_r <= 1'b0;
        end else begin
            syncA_r <= {permitN, cmpIn};
            syncB_r <= syncA_r;
            permitPrev_r <= syncB_r[4];
        end
    end

    assign cmp = syncB_r[3:0];
    assign permitNs = syncB_r[4];
    // fall detect, reset low so no false edge
    logic permitFall;
    assign permitFall = permitPrev_r && !permitNs;

    ////////////////////////////////////////////////////////////////
    // millisecond timebase
    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic tick;
    logic tStart;

    // restart on load: a phase never ends on a partial first tick
    always_comb begin
        div_nxt = (tStart || div_r == TICK_LAST) ? 16'h0000 : div_r + 16'h0001;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_nxt;
        end
    end

    assign tick = (div_r == TICK_LAST);

    ////////////////////////////////////////////////////////////////
    // registers
    logic [1:0] ctrl_r;
    logic [1:0] ctrl_nxt;
    logic [4:0] sts_r;
    logic [4:0] sts_nxt;
    logic [4:0] mask_r;
    logic [4:0] mask_nxt;
    logic [4:0] ev;
    logic [7:0] aAddr_r;
    logic aWr_r;
    logic aValid_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic tfaultIn;
    logic fullIn;
    logic tfaultPrev_r;
    cfd_pkg::cfd_state_t st_r;
    cfd_pkg::cfd_state_t st_nxt;
    logic take;
    logic wrNow;

    assign take = hsel && hready && htrans[1];
    assign wrNow = aValid_r && aWr_r;
    assign tfaultIn = ctrl_r[cfd_pkg::CTRL_TFAULT];
    assign fullIn = ctrl_r[cfd_pkg::CTRL_FULL];

    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        sts_nxt = sts_r;
        if (wrNow && aAddr_r == cfd_pkg::OFS_CTRL) begin
            ctrl_nxt = hwdata[1:0];
        end
        if (wrNow && aAddr_r == cfd_pkg::OFS_MASK) begin
            mask_nxt = hwdata[4:0];
        end
        if (wrNow && aAddr_r == cfd_pkg::OFS_IRQ) begin
            sts_nxt = sts_r & ~hwdata[4:0];
        end
        // set wins over a clear in the same cycle
        sts_nxt = sts_nxt | ev;
        rdata_nxt = 32'h00000000;
        if (take && !hwrite) begin
            case (haddr[7:0])
                cfd_pkg::OFS_CTRL: rdata_nxt = {30'h0, ctrl_r};
                cfd_pkg::OFS_STATE: rdata_nxt = {23'h0, st_r};
                cfd_pkg::OFS_IRQ: rdata_nxt = {27'h0, sts_r | ev};
                cfd_pkg::OFS_MASK: rdata_nxt = {27'h0, mask_r};
                cfd_pkg::OFS_CMP: rdata_nxt = {27'h0, permitNs, cmp};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= cfd_pkg::CTRL_RST;
            mask_r <= cfd_pkg::MASK_RST;
            sts_r <= 5'h00;
            aAddr_r <= 8'h00;
            aWr_r <= 1'b0;
            aValid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            tfaultPrev_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            sts_r <= sts_nxt;
            aAddr_r <= haddr[7:0];
            aWr_r <= hwrite;
            aValid_r <= take;
            rdata_r <= rdata_nxt;
            tfaultPrev_r <= tfaultIn;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign irq = |(sts_r & mask_r);

    ////////////////////////////////////////////////////////////////
    // detection interval timer
    logic [CW-1:0] tLoad;
    logic tExp;

    cfd_interval #(
        .CNT_W(CW)
    ) uTimer (
        .clk(clk),
        .nrst(nrst),
        .tick(tick),
        .start(tStart),
        .loadMs(tLoad),
        .expired(tExp)
    );

    ////////////////////////////////////////////////////////////////
    // sequencer
    logic tfaultRise;
    logic sleeping;
    assign tfaultRise = tfaultIn && !tfaultPrev_r;
    assign sleeping = !cmp.sleepExit;

    always_comb begin
        st_nxt = st_r;
        tStart = 1'b0;
        tLoad = CW'(DRAIN1_MS);
        ev = 5'h00;
        case (st_r)
            cfd_pkg::CFD_CHARGE: begin
                if (fullIn && cmp.aboveRecharge) begin
                    st_nxt = cfd_pkg::CFD_DONE;
                end else if (cmp.aboveRecharge && !fullIn && !permitNs) begin
                    st_nxt = cfd_pkg::CFD_DRAIN2;
                    tStart = 1'b1;
                    tLoad = CW'(DRAIN2_MS);
                end
            end
            cfd_pkg::CFD_DONE: begin
                if (!cmp.aboveRecharge) begin
                    st_nxt = cfd_pkg::CFD_DRAIN1;
                    tStart = 1'b1;
                end
            end
            cfd_pkg::CFD_TFHIGH: begin
                if (!cmp.aboveRecharge) begin
                    st_nxt = cfd_pkg::CFD_DRAIN1;
                    tStart = 1'b1;
                end
            end
            cfd_pkg::CFD_TFPROBE: begin
                if (cmp.aboveRecharge) begin
                    st_nxt = cfd_pkg::CFD_TFHIGH;
                end
            end
            cfd_pkg::CFD_OVP: begin
                if (!cmp.aboveRecharge) begin
                    st_nxt = cfd_pkg::CFD_CHARGE;
                end
            end
            cfd_pkg::CFD_DRAIN1: begin
                if (tExp) begin
                    if (cmp.belowShort) begin
                        st_nxt = cfd_pkg::CFD_WAKE;
                        tStart = 1'b1;
                        tLoad = CW'(WAKE_MS);
                    end else begin
                        st_nxt = cfd_pkg::CFD_CHARGE;
                        ev[cfd_pkg::EV_PRESENT] = 1'b1;
                    end
                end
            end
            cfd_pkg::CFD_WAKE: begin
                if (tExp) begin
                    if (cmp.aboveRecharge) begin
                        st_nxt = cfd_pkg::CFD_ABSENT;
                        ev[cfd_pkg::EV_ABSENT] = 1'b1;
                    end else begin
                        st_nxt = cfd_pkg::CFD_CHARGE;
                        ev[cfd_pkg::EV_PRESENT] = 1'b1;
                    end
                end
            end
            cfd_pkg::CFD_ABSENT: begin
                st_nxt = cfd_pkg::CFD_DRAIN2;
                tStart = 1'b1;
                tLoad = CW'(DRAIN2_MS);
            end
            cfd_pkg::CFD_DRAIN2: begin
                if (tExp) begin
                    if (!cmp.aboveRecharge) begin
                        st_nxt = cfd_pkg::CFD_DRAIN1;
                        tStart = 1'b1;
                    end else begin
                        st_nxt = cfd_pkg::CFD_ABSENT;
                    end
                end
            end
            default: st_nxt = cfd_pkg::CFD_CHARGE;
        endcase
        if (tfaultRise && (st_r == cfd_pkg::CFD_CHARGE)) begin
            st_nxt = cmp.aboveRecharge ? cfd_pkg::CFD_TFHIGH : cfd_pkg::CFD_TFPROBE;
            ev[cfd_pkg::EV_TFAULT] = 1'b1;
        end
        if (cmp.overVolt && st_r != cfd_pkg::CFD_OVP) begin
            st_nxt = cfd_pkg::CFD_OVP;
            ev[cfd_pkg::EV_OVP] = 1'b1;
        end
        if (permitFall) begin
            st_nxt = cfd_pkg::CFD_CHARGE;
            tStart = 1'b0;
            ev[cfd_pkg::EV_PERMIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= cfd_pkg::CFD_CHARGE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    cfd_pkg::cfd_drive_t drv_r;
    cfd_pkg::cfd_drive_t drv_nxt;
    logic adapterOn_r;
    logic [1:0] ind_r;
    logic [1:0] ind_nxt;

    always_comb begin
        drv_nxt = '0;
        drv_nxt.pwmEn = (st_r == cfd_pkg::CFD_CHARGE) && !permitNs && !sleeping;
        drv_nxt.probeEn = (st_r == cfd_pkg::CFD_TFPROBE);
        drv_nxt.drain1En = (st_r == cfd_pkg::CFD_DRAIN1);
        drv_nxt.wakeEn = (st_r == cfd_pkg::CFD_WAKE);
        drv_nxt.drain2En = (st_r == cfd_pkg::CFD_DRAIN2);
        ind_nxt = 2'h0;
        if (!sleeping && !permitNs) begin
            if (st_r == cfd_pkg::CFD_CHARGE) begin
                ind_nxt = 2'h1;
            end else if (st_r == cfd_pkg::CFD_DONE) begin
                ind_nxt = 2'h2;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drv_r <= '0;
            adapterOn_r <= 1'b0;
            ind_r <= 2'h0;
        end else begin
            drv_r <= drv_nxt;
            adapterOn_r <= !sleeping;
            ind_r <= ind_nxt;
        end
    end

    assign drive = drv_r;
    assign adapterPresentOutOe = adapterOn_r;
    assign chargeIndicatorPinsOe = ind_r;
endmodule

/* tb/cfd_sequencer_asserts.sv */
// port checker for the charger fault and pack detect sequencer
`timescale 1ns/10ps
module cfd_sequencer_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire cfd_pkg::cfd_cmp_t cmpIn,
    input wire logic permitN,
    input wire cfd_pkg::cfd_drive_t drive,
    input wire logic adapterPresentOutOe,
    input wire logic [1:0] chargeIndicatorPinsOe,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////////
    // six cycles of stable input cover the sync stages plus output register
    AST_ADAPTER_ON: assert property (cmpIn.sleepExit [*6] |-> adapterPresentOutOe)
        else $error("adapter output not on after sleep exit");
    AST_ADAPTER_OFF: assert property (!cmpIn.sleepExit [*6] |-> !adapterPresentOutOe)
        else $error("adapter output on in sleep");
    AST_PERMIT_HOLD: assert property (permitN [*6] |-> !drive.pwmEn)
        else $error("converter on while permit held high");
    AST_PERMIT_CLEAR: assert property ($fell(permitN) |-> ##5 !drive.probeEn)
        else $error("probe current survives permit fall");
    AST_OVP_STOP: assert property (cmpIn.overVolt [*6] |->
        !drive.pwmEn && chargeIndicatorPinsOe == 2'h0)
        else $error("converter or indicators on in overvoltage");
    AST_PROBE_QUIET: assert property (drive.probeEn |-> chargeIndicatorPinsOe == 2'h0)
        else $error("indicators on during timer fault");
    AST_ONE_SOURCE: assert property ($onehot0(drive))
        else $error("more than one source enabled");
    AST_WAKE_AFTER_DRAIN: assert property ($rose(drive.wakeEn) |-> $past(drive.drain1En))
        else $error("wake current not preceded by first drain");
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus stalled or error response");

    cover property ($rose(drive.probeEn));
    cover property ($rose(drive.wakeEn));
    cover property ($rose(drive.drain2En));
endmodule

bind cfd_sequencer cfd_sequencer_asserts u_chk (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmpIn(cmpIn),
    .permitN(permitN), .drive(drive), .adapterPresentOutOe(adapterPresentOutOe),
    .chargeIndicatorPinsOe(chargeIndicatorPinsOe), .irq(irq));

/* tb/cfd_pack_model.sv */
// pack and supply comparator model for the sequencer bench
`timescale 1ns/10ps
module cfd_pack_model (
    input wire logic clk,
    input wire cfd_pkg::cfd_drive_t drive,
    input wire logic packIn,
    input wire logic supplyIn,
    input wire logic cellAbove,
    input wire logic ovIn,
    output cfd_pkg::cfd_cmp_t cmp
);
    logic railHigh_r = 1'b0;

    // empty rail rises from converter or wake source, falls under a drain
    always_ff @(posedge clk) begin
        if (drive.pwmEn || drive.wakeEn) begin
            railHigh_r <= 1'b1;
        end else if (drive.drain1En || drive.drain2En) begin
            railHigh_r <= 1'b0;
        end
    end

    // a fitted pack hides the rail and never reads as shorted
    assign cmp = packIn ? {cellAbove, 1'b0, ovIn, supplyIn}
                        : {railHigh_r, !railHigh_r, ovIn, supplyIn};
endmodule

/* tb/test_charger_fault_and_pack_detect_fsm.sv */
// self-checking bench for the charger fault and pack detect sequencer
`timescale 1ns/10ps
module test_charger_fault_and_pack_detect_fsm;
    logic clk, nrst, hsel, hwrite, permitN, packIn, supplyIn, cellAbove, ovIn;
    logic hreadyout, hresp, apOe, irq;
    logic [1:0] htrans, indOe;
    logic [31:0] haddr, hwdata, hrdata, rd, v;
    cfd_pkg::cfd_cmp_t cmpIn;
    cfd_pkg::cfd_drive_t drive, lastDrv;
    int error_cnt = 0, compares = 0, cyc = 0, seed = 12;
    int gotQ[$];
    int expQ[$] = '{1, 4, 2, 1};

    cfd_sequencer #(.DRAIN1_MS(2), .WAKE_MS(1), .DRAIN2_MS(2), .TICK_LAST(16'h0009)) DUT (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .cmpIn(cmpIn), .permitN(permitN), .drive(drive),
        .adapterPresentOutOe(apOe), .chargeIndicatorPinsOe(indOe), .irq(irq));
    cfd_pack_model PM (.clk(clk), .drive(drive), .packIn(packIn), .supplyIn(supplyIn),
        .cellAbove(cellAbove), .ovIn(ovIn), .cmp(cmpIn));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reference: record each new nonzero source pattern; cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        lastDrv <= drive;
        if (drive !== lastDrv && drive !== 5'h00) gotQ.push_back(int'(drive));
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0t timeout", $time);
            conclude();
        end
    end

    task conclude;
        $display("counts: mismatches %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task cmpPin(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // single transfer; waits on hready in both phases
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task cmpReg(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        cmpPin(rd, e);
    endtask

    function automatic logic [31:0] st(input cfd_pkg::cfd_state_t s);
        return 32'(s);
    endfunction

    // input sync plus output register, with margin
    task settle;
        repeat (6) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {permitN, supplyIn, cellAbove, ovIn, lastDrv} = '0;
        packIn = 1'b1;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        hsel <= 1'b1;
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_CHARGE));
        cmpReg(cfd_pkg::OFS_MASK, 32'(cfd_pkg::MASK_RST));
        cmpReg(cfd_pkg::OFS_CTRL, 32'(cfd_pkg::CTRL_RST));
        cmpReg(32'h20, 32'h0);
        cmpPin(apOe, 0);
        supplyIn <= 1'b1;
        settle();
        cmpPin(apOe, 1);
        $display("test reset and adapter done");

        permitN <= 1'b1;
        settle();
        cmpPin(drive.pwmEn, 0);
        permitN <= 1'b0;
        settle();
        cmpPin(drive.pwmEn, 1);
        cmpPin(indOe, 2'h1);
        cmpReg(cfd_pkg::OFS_IRQ, 32'h10);
        v = $random(seed);
        ahb(1'b1, cfd_pkg::OFS_MASK, v);
        cmpReg(cfd_pkg::OFS_MASK, v & 32'h1F);
        cmpPin(irq, v[4]);
        ahb(1'b1, cfd_pkg::OFS_MASK, 32'h1F);
        ahb(1'b1, cfd_pkg::OFS_IRQ, 32'h1F);
        // clear lands on the edge the task returns at
        @(negedge clk);
        cmpPin(irq, 0);
        $display("test permit and interrupt done");

        ahb(1'b1, cfd_pkg::OFS_CTRL, 32'h1);
        settle();
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_TFPROBE));
        cmpPin(drive.probeEn, 1);
        cmpPin(irq, 1);
        cellAbove <= 1'b1;
        settle();
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_TFHIGH));
        cmpPin(drive.probeEn, 0);
        cellAbove <= 1'b0;
        settle();
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_DRAIN1));
        repeat (40) @(posedge clk);
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_CHARGE));
        ahb(1'b1, cfd_pkg::OFS_CTRL, 32'h0);
        ahb(1'b1, cfd_pkg::OFS_CTRL, 32'h1);
        settle();
        permitN <= 1'b1;
        settle();
        permitN <= 1'b0;
        settle();
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_CHARGE));
        cmpPin(drive.probeEn, 0);
        ahb(1'b1, cfd_pkg::OFS_CTRL, 32'h0);
        $display("test timer fault done");

        ovIn <= 1'b1;
        cellAbove <= 1'b1;
        settle();
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_OVP));
        cmpPin({drive.pwmEn, indOe}, 0);
        ovIn <= 1'b0;
        settle();
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_OVP));
        cellAbove <= 1'b0;
        settle();
        ahb(1'b0, cfd_pkg::OFS_STATE, 32'h0);
        cmpPin(rd[4], 0);
        repeat (40) @(posedge clk);
        $display("test overvoltage done");

        gotQ.delete();
        packIn <= 1'b0;
        repeat (150) @(posedge clk);
        // removal drain, first drain, wake, then drain again
        for (int i = 0; i < 4; i++) cmpPin(32'(gotQ[i]), 32'(expQ[i]));
        ahb(1'b0, cfd_pkg::OFS_IRQ, 32'h0);
        cmpPin(rd[cfd_pkg::EV_ABSENT], 1);
        cmpPin(indOe, 2'h0);
        // drop the present flag left by the timer fault test
        ahb(1'b1, cfd_pkg::OFS_IRQ, 32'h1F);
        ahb(1'b0, cfd_pkg::OFS_IRQ, 32'h0);
        cmpPin(rd[cfd_pkg::EV_PRESENT], 0);
        packIn <= 1'b1;
        repeat (60) @(posedge clk);
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_CHARGE));
        ahb(1'b0, cfd_pkg::OFS_IRQ, 32'h0);
        cmpPin(rd[cfd_pkg::EV_PRESENT], 1);
        $display("test pack detection done");

        ahb(1'b1, cfd_pkg::OFS_CTRL, 32'h2);
        cellAbove <= 1'b1;
        settle();
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_DONE));
        cmpPin(indOe, 2'h2);
        cellAbove <= 1'b0;
        settle();
        cmpReg(cfd_pkg::OFS_STATE, st(cfd_pkg::CFD_DRAIN1));
        $display("test charge complete and recharge done");
        conclude();
    end
endmodule
